// ==== hw/aim_map.svh ====
`ifndef AIM_MAP_SVH
`define AIM_MAP_SVH
`define AIM_AXES 4
`define AIM_MARK_MIN_NS 150000
`define AIM_CLK_NS 4
`define AIM_MARK_MIN_CYC ((`AIM_MARK_MIN_NS + `AIM_CLK_NS - 1) / `AIM_CLK_NS)
`define AIM_SYNC_STAGES 2
`define AIM_VEL_W 16
`define AIM_BLOCK_W 12
`endif

// ==== hw/aim_pkg.sv ====
package aim_pkg;
   typedef enum logic [1:0] {
      AIM_MANUAL = 2'b00,
      AIM_AUTO = 2'b01,
      AIM_PARAM = 2'b10
   } aim_mode_type;
endpackage

// ==== hw/aim_sync.sv ====
`timescale 1ns/1ns
`include "aim_map.svh"
module aim_sync #(
   parameter int WIDTH = 8
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   // =====================================
   // two-stage synchroniser
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= async_i;
         sync_reg <= meta_reg;
      end
   end
   assign sync_o = sync_reg;
endmodule

// ==== hw/aim_top.sv ====
`timescale 1ns/1ns
`include "aim_map.svh"
module aim_top #(
   parameter int AXES = `AIM_AXES,
   parameter int VEL_W = `AIM_VEL_W,
   parameter int BLOCK_W = `AIM_BLOCK_W
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic auto_select_i,
   input wire logic param_select_i,
   input wire logic [AXES-1:0] jog_reverse_i,
   input wire logic [AXES-1:0] amp_ready_i,
   input wire logic restart_request_i,
   input wire logic mark_input_i,
   input wire logic mark_search_i,
   input wire logic error_i,
   input wire logic hard_fault_i,
   input wire logic auto_permit_i,
   input wire logic restart_condition_i,
   input wire logic restart_enable_i,
   input wire logic [BLOCK_W-1:0] restart_routine_setting_i,
   input wire logic [VEL_W-1:0] jog_velocity_setting_i,
   output aim_pkg::aim_mode_type mode_o,
   output logic manual_ind_o,
   output logic auto_ind_o,
   output logic param_ind_o,
   output logic invalid_mode_o,
   output logic [AXES-1:0] amplifier_enable_out_o,
   output logic [AXES-1:0] amp_confirm_o,
   output logic [AXES-1:0] jog_reverse_active_o,
   output logic [VEL_W-1:0] jog_reverse_velocity_o,
   output logic restart_possible_o,
   output logic restart_launch_o,
   output logic [BLOCK_W-1:0] restart_block_o,
   output logic mark_event_o,
   output logic mark_present_o
);
   import aim_pkg::*;

   // =====================================
   // input synchronisation
   localparam int SW = 2 * AXES + 4;
   logic [SW-1:0] raw_in;
   logic [SW-1:0] sync_in;
   assign raw_in = {auto_select_i, param_select_i, jog_reverse_i, amp_ready_i, restart_request_i, mark_input_i};

   aim_sync #(.WIDTH(SW)) u_sync (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .async_i(raw_in),
      .sync_o(sync_in)
   );

   wire auto_s = sync_in[SW-1];
   wire param_s = sync_in[SW-2];
   wire [AXES-1:0] jog_s = sync_in[2*AXES+1:AXES+2];
   wire [AXES-1:0] ready_s = sync_in[AXES+1:2];
   wire restart_s = sync_in[1];
   wire mark_s = sync_in[0];

   // one-cycle event on a low-to-high step of a synchronised level
   function automatic logic rise_of(input logic now_v, input logic last_v);
      return now_v & ~last_v;
   endfunction

   // =====================================
   // mode selection
   aim_mode_type mode_reg;
   aim_mode_type mode_next;
   logic sampled_reg;
   // parameter overrides; automatic comes back by itself once param drops because select is level
   assign mode_next = param_s ? AIM_PARAM : (auto_s ? AIM_AUTO : AIM_MANUAL);
   wire invalid_w = auto_s & param_s;
   wire err_any = error_i | hard_fault_i | invalid_mode_o;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         mode_reg <= AIM_MANUAL;
         sampled_reg <= 1'b0;
      end else begin
         mode_reg <= mode_next;
         sampled_reg <= 1'b1;
      end
   end
   assign mode_o = mode_reg;

   // =====================================
   // indicators and amplifier enables
   logic manual_reg;
   logic auto_reg;
   logic param_reg;
   logic invalid_reg;
   logic [AXES-1:0] amp_reg;
   wire is_manual = (mode_reg == AIM_MANUAL);
   wire is_auto = (mode_reg == AIM_AUTO);
   wire is_param = (mode_reg == AIM_PARAM);
   wire [AXES-1:0] amp_next = (is_param | hard_fault_i | ~sampled_reg) ? '0 : ready_s;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         manual_reg <= 1'b1;
         auto_reg <= 1'b0;
         param_reg <= 1'b0;
         invalid_reg <= 1'b0;
         amp_reg <= '0;
      end else begin
         // error must pull manual low even though the mode stays manual
         manual_reg <= is_manual & ~err_any;
         auto_reg <= is_auto & auto_permit_i & ~hard_fault_i & ~error_i;
         param_reg <= is_param;
         invalid_reg <= invalid_w;
         amp_reg <= amp_next;
      end
   end
   assign manual_ind_o = manual_reg;
   assign auto_ind_o = auto_reg;
   assign param_ind_o = param_reg;
   assign invalid_mode_o = invalid_reg;
   assign amplifier_enable_out_o = amp_reg;
   assign amp_confirm_o = amp_reg;

   // =====================================
   // reverse jog
   logic [AXES-1:0] jog_reg;
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         jog_reg <= '0;
      end else begin
         // release stops at once; amplifier must be enabled to move
         jog_reg <= is_manual ? (jog_s & amp_next) : '0;
      end
   end
   assign jog_reverse_active_o = jog_reg;
   logic [VEL_W-1:0] vel_reg;
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         vel_reg <= '0;
      end else begin
         vel_reg <= jog_velocity_setting_i;
      end
   end
   assign jog_reverse_velocity_o = vel_reg;

   // =====================================
   // restart request
   logic restart_d_reg;
   logic launch_reg;
   logic possible_reg;
   logic [BLOCK_W-1:0] block_reg;
   wire restart_rise = rise_of(restart_s, restart_d_reg);
   wire possible_w = restart_enable_i & restart_condition_i;
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         restart_d_reg <= 1'b0;
         launch_reg <= 1'b0;
         possible_reg <= 1'b0;
         block_reg <= '0;
      end else begin
         restart_d_reg <= restart_s;
         launch_reg <= restart_rise & possible_w;
         possible_reg <= possible_w;
         block_reg <= restart_routine_setting_i;
      end
   end
   assign restart_launch_o = launch_reg;
   assign restart_possible_o = possible_reg;
   assign restart_block_o = block_reg;

   // =====================================
   // registration mark
   // only the primary mark input exists; secondary ones are left out on purpose
   logic mark_d_reg;
   logic mark_ev_reg;
   logic mark_lvl_reg;
   wire mark_rise = rise_of(mark_s, mark_d_reg);
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         mark_d_reg <= 1'b0;
         mark_ev_reg <= 1'b0;
         mark_lvl_reg <= 1'b0;
      end else begin
         mark_d_reg <= mark_s;
         // sampled every cycle, so far shorter pulses than 150 us are caught
         mark_ev_reg <= mark_rise & mark_search_i;
         mark_lvl_reg <= mark_s;
      end
   end
   assign mark_event_o = mark_ev_reg;
   assign mark_present_o = mark_lvl_reg;

   // =====================================
   // checks
   amp_param_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      is_param |=> amplifier_enable_out_o == '0) else $error("amp on in param mode");
   amp_mirror_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      amp_confirm_o == amplifier_enable_out_o) else $error("confirm differs");
   jog_ignore_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      !is_manual |=> jog_reverse_active_o == '0) else $error("jog outside manual");
   jog_stop_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      !jog_s[0] |=> !jog_reverse_active_o[0]) else $error("jog not stopped");
   restart_gate_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      restart_launch_o |-> $past(possible_w) && $past(restart_rise)) else $error("bad restart");
   restart_one_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      restart_launch_o |=> !restart_launch_o) else $error("restart not one cycle");
   param_ind_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      param_s |-> ##2 param_ind_o) else $error("param indicator missing");
   invalid_sel_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      invalid_w |=> invalid_mode_o ##1 !manual_ind_o) else $error("invalid mode missed");
   manual_err_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      error_i |=> !manual_ind_o) else $error("manual during error");
   mark_catch_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      mark_search_i && mark_rise |=> mark_event_o) else $error("mark missed");
   amp_fault_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      hard_fault_i |=> amplifier_enable_out_o == '0) else $error("amp on during hard fault");
   auto_fault_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      hard_fault_i |=> !auto_ind_o) else $error("auto shown during hard fault");
endmodule

// ==== tb/aim_sensor_model.sv ====
`timescale 1ns/1ns
`include "aim_map.svh"
// ==========
// registration sensor
// holds every mark for exactly the minimum width, the worst case the block must catch
module aim_sensor_model (
   input wire logic ref_clk_i,
   input wire logic fire_i,
   output logic mark_o
);
   int hold_cnt = 0;
   // only the main mark input is modelled; secondary inputs stay unused
   always @(posedge ref_clk_i) begin
      if (fire_i) begin
         hold_cnt <= `AIM_MARK_MIN_CYC;
      end else if (hold_cnt > 0) begin
         hold_cnt <= hold_cnt - 1;
      end
   end
   assign mark_o = (hold_cnt > 0);
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ns
`include "aim_map.svh"
module testbench;
   import aim_pkg::*;
   logic ref_clk_i, rst_i, asel, psel, rreq, mark, msrch, err, hf, perm, rcond, ren, fire;
   logic [3:0] jog, rdy, amp, conf, jact;
   logic [11:0] rset, rblk;
   logic [15:0] vel, jvel;
   aim_mode_type mode;
   logic man, aut, par, inv, rposs, rlaunch, mev, mpres;
   int err_total = 0;
   int check_count = 0;
   int launch_cnt = 0;
   int event_cnt = 0;
   int cyc = 0;
   int base;
   // ==========
   // design and sensor
   aim_top DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .auto_select_i(asel), .param_select_i(psel),
      .jog_reverse_i(jog), .amp_ready_i(rdy), .restart_request_i(rreq), .mark_input_i(mark),
      .mark_search_i(msrch), .error_i(err), .hard_fault_i(hf), .auto_permit_i(perm),
      .restart_condition_i(rcond), .restart_enable_i(ren), .restart_routine_setting_i(rset),
      .jog_velocity_setting_i(vel), .mode_o(mode), .manual_ind_o(man), .auto_ind_o(aut),
      .param_ind_o(par), .invalid_mode_o(inv), .amplifier_enable_out_o(amp), .amp_confirm_o(conf),
      .jog_reverse_active_o(jact), .jog_reverse_velocity_o(jvel), .restart_possible_o(rposs),
      .restart_launch_o(rlaunch), .restart_block_o(rblk), .mark_event_o(mev), .mark_present_o(mpres));
   aim_sensor_model sensor (.ref_clk_i(ref_clk_i), .fire_i(fire), .mark_o(mark));
   // ==========
   // clock, pulse counters, timeout
   initial begin
      ref_clk_i = 1'b0;
      forever #2 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (rlaunch === 1'b1) launch_cnt <= launch_cnt + 1;
      if (mev === 1'b1) event_cnt <= event_cnt + 1;
      if (cyc == 90000) begin
         err_total++;
         conclude();
      end
   end
   // ==========
   // tasks
   task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // outputs settle four cycles after a pin change; six leaves margin
   task settle(input int n = 6);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   task conclude();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // ==========
   // sequence
   initial begin
      rst_i = 1'b1; asel = 0; psel = 0; rreq = 0; msrch = 0; err = 0; hf = 0; perm = 0;
      rcond = 0; ren = 0; fire = 0; jog = 4'h0; rdy = 4'hF; rset = 12'hABC; vel = 16'h1234;
      repeat (4) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      #1;
      check("man_rst", man, 1'b1);
      check("amp_rst", amp, 4'h0);
      settle();
      check("man", man, 1'b1);
      check("mode", mode, AIM_MANUAL);
      check("amp", amp, 4'hF);
      check("conf", conf, 4'hF);
      @(posedge ref_clk_i) jog <= 4'h5;
      settle();
      check("jact", jact, 4'h5);
      check("jvel", jvel, 16'h1234);
      @(posedge ref_clk_i) jog <= 4'h0;
      settle();
      check("jact_off", jact, 4'h0);
      @(posedge ref_clk_i) {asel, perm, jog} <= {2'b11, 4'hF};
      settle();
      check("aut", aut, 1'b1);
      check("man_aut", man, 1'b0);
      check("jact_aut", jact, 4'h0);
      @(posedge ref_clk_i) perm <= 1'b0;
      settle();
      check("aut_noperm", aut, 1'b0);
      @(posedge ref_clk_i) {perm, psel} <= 2'b11;
      settle();
      check("par", par, 1'b1);
      check("inv", inv, 1'b1);
      check("amp_par", amp, 4'h0);
      check("jact_par", jact, 4'h0);
      @(posedge ref_clk_i) {psel, jog} <= {1'b0, 4'h0};
      settle();
      check("aut_back", aut, 1'b1);
      check("par_off", par, 1'b0);
      @(posedge ref_clk_i) {asel, err} <= 2'b01;
      settle();
      check("man_err", man, 1'b0);
      @(posedge ref_clk_i) {err, rdy} <= {1'b0, 4'hE};
      settle();
      check("amp_rdy", amp, 4'hE);
      check("conf_rdy", conf, 4'hE);
      @(posedge ref_clk_i) hf <= 1'b1;
      settle();
      check("amp_hf", amp, 4'h0);
      @(posedge ref_clk_i) {hf, rdy} <= {1'b0, 4'hF};
      for (int i = 1; i < 4; i++) begin
         @(posedge ref_clk_i) {ren, rcond} <= i[1:0];
         settle();
         check("rposs", rposs, i == 3);
         base = launch_cnt;
         @(posedge ref_clk_i) rreq <= 1'b1;
         settle(2);
         @(posedge ref_clk_i) rreq <= 1'b0;
         settle();
         check("launches", launch_cnt - base, i == 3);
      end
      check("rblk", rblk, 12'hABC);
      for (int s = 0; s < 2; s++) begin
         base = event_cnt;
         @(posedge ref_clk_i) {msrch, fire} <= {s[0], 1'b1};
         @(posedge ref_clk_i) fire <= 1'b0;
         settle(100);
         check("mpres", mpres, 1'b1);
         settle(`AIM_MARK_MIN_CYC);
         check("mevents", event_cnt - base, s);
      end
      // ==========
      // fault in automatic, then a reset in mid-run
      @(posedge ref_clk_i) {asel, perm} <= 2'b11;
      settle();
      check("aut_pre", aut, 1'b1);
      @(posedge ref_clk_i) hf <= 1'b1;
      settle();
      check("aut_hf", aut, 1'b0);
      check("amp_hf2", amp, 4'h0);
      @(posedge ref_clk_i) {hf, rst_i} <= 2'b01;
      repeat (2) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      #1;
      check("man_rst2", man, 1'b1);
      check("aut_rst2", aut, 1'b0);
      check("amp_rst2", amp, 4'h0);
      @(posedge ref_clk_i);
      #1;
      check("amp_first", amp, 4'h0);
      check("mode_first", mode, AIM_MANUAL);
      check("man_first", man, 1'b1);
      settle();
      check("aut_resume", aut, 1'b1);
      check("amp_resume", amp, 4'hF);
      conclude();
   end
endmodule
